// ===== core/periodic_tick_and_watchdog_divider.sv
// Purpose: Periodic tick, watchdog clock chain and counter bypass test
//          feature, with an AXI4-Lite register slave.
// Assumes: One clock aclk at 10 MHz; special_mode is a level from the
//          mode logic, synchronous to aclk.
// Notes:   Counts are taken at a bus cycle rate of one per aclk edge.
//          The divider chain is cleared by system reset only, so the
//          tap phase is unknown to software after a service write.
//          Register writes act on the low byte only, and only when
//          the low byte strobe is set; other bytes read back as zero, except the counter's upper byte.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Bypass clocks both counter halves each cycle
// - Bypass bit writable only in special mode
// - Tick divider free-runs, ignores flag clearing
// - Flag set at each period end
// - Writing one at bit six clears flag
// - Writing zero leaves a flag alone
// - Enable never touches flag set or clear
// - Enabled flag raises interrupt request
// - Flag stays set until software clears
// - Base tick is clock divided by 8192
// - Rate select divides by 1,2,4,8
// - Rate resets to fastest, writable anytime
// - Stages after watchdog tap cleared by service
// - Watchdog rate divides by 1,4,16,64
// - Watchdog rate resets to shortest timeout
// - Normal mode: one watchdog write, first 64 cycles
// - First watchdog edge uncertainty independent of rate
module periodic_tick_and_watchdog_divider
    import tick_divider_pkg::*;
#(
    parameter int PERIODIC_DIV = PERIODIC_DIV_DEF,
    parameter int WATCHDOG_DIV = WATCHDOG_DIV_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic special_mode,
    input wire logic [15:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    output logic watchdog_tick,
    output logic [15:0] timer_count
);

    tick_state_s st;
    tick_state_s next_st;

    logic base_tick;
    logic wd_tap;
    logic period_end;
    logic do_write;
    logic [13:0] widx;
    logic [31:0] read_word;
    logic read_ok;

    // Word index of a byte address.
    function automatic logic [13:0] word_index(input logic [15:0] addr);
        word_index = addr[15:2];
    endfunction

    // Extra division mask of the periodic tick for a rate code.
    function automatic logic [2:0] tick_mask(input logic [1:0] code);
        case (code)
            2'h0:
            begin
                tick_mask = TICK_MASK_1;
            end
            2'h1:
            begin
                tick_mask = TICK_MASK_2;
            end
            2'h2:
            begin
                tick_mask = TICK_MASK_4;
            end
            default:
            begin
                tick_mask = TICK_MASK_8;
            end
        endcase
    endfunction

    // Extra division mask of the watchdog clock for a rate code.
    function automatic logic [5:0] wd_mask(input logic [1:0] code);
        case (code)
            2'h0:
            begin
                wd_mask = WD_MASK_1;
            end
            2'h1:
            begin
                wd_mask = WD_MASK_4;
            end
            2'h2:
            begin
                wd_mask = WD_MASK_16;
            end
            default:
            begin
                wd_mask = WD_MASK_64;
            end
        endcase
    endfunction

    // Register read multiplexer; unmapped words answer with an error.
    always_comb
    begin
        read_word = '0;
        read_ok = 1'b1;
        case (word_index(araddr))
            IDX_COUNTER:
            begin
                read_word[15:0] = st.counter;
            end
            IDX_IRQ_MASK:
            begin
                read_word[PERIODIC_BIT] = st.periodic_irq_enable;
            end
            IDX_FLAGS:
            begin
                read_word[PERIODIC_BIT] = st.periodic_flag;
            end
            IDX_TICK_CTRL:
            begin
                read_word[RATE_HI:RATE_LO] = st.periodic_rate;
            end
            IDX_WD_OPTION:
            begin
                read_word[RATE_HI:RATE_LO] = st.watchdog_rate;
            end
            IDX_WD_SERVICE:
            begin
                read_word = '0;
            end
            IDX_TEST_CTRL:
            begin
                read_word[BYPASS_BIT] = st.counter_bypass_bit;
            end
            default:
            begin
                read_ok = 1'b0;
            end
        endcase
    end

    // Taps of the free-running divider chain.
    assign base_tick = (st.chain & CHAIN_W'(PERIODIC_DIV - 1))
        == CHAIN_W'(PERIODIC_DIV - 1);
    assign wd_tap = (st.chain & CHAIN_W'(WATCHDOG_DIV - 1))
        == CHAIN_W'(WATCHDOG_DIV - 1);
    assign period_end = base_tick
        && ((st.tick_sub & tick_mask(st.periodic_rate))
        == tick_mask(st.periodic_rate));
    assign do_write = st.aw_held && st.w_held && !st.bvalid;
    assign widx = word_index(st.waddr);

    // Next-state logic for the whole block.
    always_comb
    begin
        next_st = st;

        // Divider chain runs on every cycle; tick sub-divider steps on each base tick.
        next_st.chain = st.chain + CHAIN_W'(1);
        if (base_tick)
        begin
            next_st.tick_sub = st.tick_sub + 3'h1;
        end

        // Free-running counter, both halves stepped together in bypass.
        if (st.counter_bypass_bit)
        begin
            next_st.counter[15:8] = st.counter[15:8] + 8'h01;
            next_st.counter[7:0] = st.counter[7:0] + 8'h01;
        end
        else
        begin
            next_st.counter = st.counter + 16'h0001;
        end

        // Window after reset during which the watchdog rate may be set.
        if (st.boot_cnt != BOOT_WINDOW)
        begin
            next_st.boot_cnt = st.boot_cnt + 7'h01;
        end

        // Watchdog stages after the tap.
        next_st.wd_tick = 1'b0;
        if (wd_tap)
        begin
            next_st.wd_stage = st.wd_stage + 6'h01;
            next_st.wd_tick = (st.wd_stage & wd_mask(st.watchdog_rate))
                == wd_mask(st.watchdog_rate);
        end

        // Write address and data channels are taken independently.
        if (awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.waddr = awaddr;
        end
        if (wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata = wdata[7:0];
            next_st.wstrb0 = wstrb[0];
        end
        if (st.bvalid && bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // Register write effects once both halves of a write are held.
        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            case (widx)
                IDX_IRQ_MASK:
                    if (st.wstrb0)
                    begin
                        next_st.periodic_irq_enable = st.wdata[PERIODIC_BIT];
                    end
                IDX_FLAGS:
                    if (st.wstrb0 && st.wdata[PERIODIC_BIT])
                    begin
                        next_st.periodic_flag = 1'b0;
                    end
                IDX_TICK_CTRL:
                    if (st.wstrb0)
                    begin
                        next_st.periodic_rate =
                            st.wdata[RATE_HI:RATE_LO];
                    end
                IDX_WD_OPTION:
                    if (st.wstrb0 && (special_mode || (!st.watchdog_rate_done
                        && st.boot_cnt != BOOT_WINDOW)))
                    begin
                        next_st.watchdog_rate = st.wdata[RATE_HI:RATE_LO];
                        next_st.watchdog_rate_done = 1'b1;
                    end
                IDX_WD_SERVICE:
                    if (st.wstrb0)
                    begin
                        next_st.wd_stage = '0;
                        next_st.wd_tick = 1'b0;
                    end
                IDX_TEST_CTRL:
                    if (st.wstrb0 && special_mode)
                    begin
                        next_st.counter_bypass_bit = st.wdata[BYPASS_BIT];
                    end
                IDX_COUNTER:
                begin
                    next_st.bresp = RESP_OKAY;
                end
                default:
                begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end

        // A period end sets the flag after any clear, so the set wins.
        // A tick that meets a clear in one cycle is therefore never lost.
        if (period_end)
        begin
            next_st.periodic_flag = 1'b1;
        end

        // Interrupt level follows flag and enable only.
        next_st.irq = next_st.periodic_flag
            && next_st.periodic_irq_enable;

        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;

        // Read channel answers one cycle after the address is taken.
        if (st.rvalid && rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word;
            next_st.rresp = read_ok ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;
    end

    // State register; rate selects come out of reset at code zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= STATE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign irq = st.irq;
    assign watchdog_tick = st.wd_tick;
    assign timer_count = st.counter;

endmodule

`default_nettype wire

// ===== core/tick_divider_pkg.sv
// Purpose: Shared constants and state layout for the periodic tick and
//          watchdog divider block.
// Assumes: 32-bit AXI4-Lite register access, one register per word, 8-bit except the 16-bit counter.
// Notes:   Register offsets are word indices; byte address is four times.
package tick_divider_pkg;

    // Register word indices; the byte address is the index times four.
    localparam logic [13:0] IDX_COUNTER = 14'h100e;
    localparam logic [13:0] IDX_IRQ_MASK = 14'h1024;
    localparam logic [13:0] IDX_FLAGS = 14'h1025;
    localparam logic [13:0] IDX_TICK_CTRL = 14'h1026;
    localparam logic [13:0] IDX_WD_OPTION = 14'h1039;
    localparam logic [13:0] IDX_WD_SERVICE = 14'h103a;
    localparam logic [13:0] IDX_TEST_CTRL = 14'h103e;

    // Field positions inside the 8-bit registers.
    localparam int PERIODIC_BIT = 6;
    localparam int BYPASS_BIT = 0;
    localparam int RATE_LO = 0;
    localparam int RATE_HI = 1;

    // Divider chain geometry and default tap ratios.
    localparam int CHAIN_W = 15;
    localparam int PERIODIC_DIV_DEF = 8192;
    localparam int WATCHDOG_DIV_DEF = 32768;
    localparam logic [6:0] BOOT_WINDOW = 7'h40;

    // Masks for the extra division after each tap.
    localparam logic [2:0] TICK_MASK_1 = 3'h0;
    localparam logic [2:0] TICK_MASK_2 = 3'h1;
    localparam logic [2:0] TICK_MASK_4 = 3'h3;
    localparam logic [2:0] TICK_MASK_8 = 3'h7;
    localparam logic [5:0] WD_MASK_1 = 6'h00;
    localparam logic [5:0] WD_MASK_4 = 6'h03;
    localparam logic [5:0] WD_MASK_16 = 6'h0f;
    localparam logic [5:0] WD_MASK_64 = 6'h3f;

    // Bus answer codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Whole state of the block, registered as one word.
    typedef struct packed {
        logic [CHAIN_W-1:0] chain;
        logic [2:0] tick_sub;
        logic periodic_flag;
        logic periodic_irq_enable;
        logic [1:0] periodic_rate;
        logic [1:0] watchdog_rate;
        logic watchdog_rate_done;
        logic [6:0] boot_cnt;
        logic counter_bypass_bit;
        logic [5:0] wd_stage;
        logic wd_tick;
        logic [15:0] counter;
        logic irq;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [15:0] waddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tick_state_s;

    localparam tick_state_s STATE_RESET = '0;

endpackage

// ===== bench/tick_divider_assertions.sv
// Purpose: Concurrent checks on the tick divider ports.
// Assumes: The helper count runs from reset release like the chain.
// Notes: Bound into every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module tick_divider_assertions #(
    parameter int PERIODIC_DIV = 16,
    parameter int WATCHDOG_DIV = 64
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic irq,
    input wire logic watchdog_tick,
    input wire logic [15:0] timer_count
);
    int cnt;

    // Cycles since reset release, the same count as the divider chain.
    always_ff @(posedge aclk)
        cnt <= aresetn ? cnt + 1 : 0;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_count;
        $past(aresetn) |-> timer_count == $past(timer_count) + 16'h1 ||
            timer_count == {$past(timer_count[15:8]) + 8'h1,
            $past(timer_count[7:0]) + 8'h1};
    endproperty
    a_count: assert property (p_count)
        else $error("counter step wrong");
    property p_tick;
        $rose(irq) |-> cnt % PERIODIC_DIV == 0 || bvalid || $past(bvalid);
    endproperty
    a_tick: assert property (p_tick)
        else $error("periodic request off the tick grid");
    property p_irq_fall;
        $fell(irq) |-> bvalid || $past(bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("request dropped without a write");
    property p_wd;
        watchdog_tick |-> cnt % WATCHDOG_DIV == 0;
    endproperty
    a_wd: assert property (p_wd)
        else $error("watchdog clock off the tap grid");
    property p_wd_pulse;
        watchdog_tick |=> !watchdog_tick [*8];
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog clock too long");
    property p_bone;
        bvalid && bready |=> !bvalid;
    endproperty
    a_bone: assert property (p_bone)
        else $error("write answer repeated");
    property p_rlock;
        rvalid |-> !arready;
    endproperty
    a_rlock: assert property (p_rlock)
        else $error("read taken while answer pending");
    property p_wlock;
        bvalid |-> !awready && !wready;
    endproperty
    a_wlock: assert property (p_wlock)
        else $error("write taken while answer pending");
endmodule

bind periodic_tick_and_watchdog_divider tick_divider_assertions #(
    .PERIODIC_DIV(PERIODIC_DIV), .WATCHDOG_DIV(WATCHDOG_DIV)) i_chk (
    .aclk, .aresetn, .awready, .wready, .bvalid, .bready, .arready,
    .rvalid, .irq, .watchdog_tick, .timer_count);
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the tick and watchdog divider.
// Assumes: Short ratios, 16 for the tick and 64 for the watchdog.
// Notes: Read answers are matched by a monitor against a queue.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
    import tick_divider_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic special_mode = 1'b0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic irq_q = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [3:0] wstrb = 4'h1;
    logic [1:0] bresp;
    logic [1:0] bexp_q[$];
    logic [1:0] bexp_r;
    logic [33:0] exp_r;
    logic awready, wready, bvalid, arready, rvalid, irq, watchdog_tick;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] timer_count, t;
    logic [33:0] exp_q[$];
    int failures = 0, n_tests = 0, seed = 99771, cyc = 0, per = 0;
    int wlast = 0, k;

    always #50 aclk = ~aclk;

    periodic_tick_and_watchdog_divider #(.PERIODIC_DIV(16),
        .WATCHDOG_DIV(64)) i_dut (.aclk, .aresetn, .special_mode, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
        .watchdog_tick, .timer_count);

    // Matches read answers and the timing of tick and watchdog events.
    always @(posedge aclk)
    begin
        cyc <= aresetn ? cyc + 1 : 0;
        irq_q <= irq;
        if (rvalid && rready)
        begin
            exp_r = exp_q.pop_front();
            `CHK({rresp, rdata}, exp_r)
        end
        if (bvalid && bready)
        begin
            bexp_r = bexp_q.pop_front();
            `CHK(bresp, bexp_r)
        end
        if (irq && !irq_q && per != 0)
            `CHK(cyc % per, 0)
        if (watchdog_tick)
        begin
            if (wlast != 0)
                `CHK(cyc - wlast, 256)
            wlast = cyc;
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A wait that ran out counts as a mismatch and ends the run.
    task automatic to;
        failures++;
        final_report;
    endtask

    // Writes one register word; address and data go out together.
    task automatic wr(input logic [13:0] i, input logic [7:0] d,
        input logic [1:0] e = RESP_OKAY);
        k = 0;
        bexp_q.push_back(e);
        awaddr <= {i, 2'h0};
        wdata <= {24'($random(seed)), d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && k < 200);
        if (!bvalid) to;
    endtask

    // Reads one register word and queues the expected answer.
    task automatic rd(input logic [13:0] i, input logic [33:0] e);
        k = 0;
        exp_q.push_back(e);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && k < 200);
        if (!rvalid) to;
    endtask

    // Waits a bounded time for the interrupt request.
    task automatic wirq;
        for (k = 0; k < 300 && !irq; k++)
            @(posedge aclk);
        if (!irq) to;
    endtask

    // Main sequence.
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_TICK_CTRL, 34'h0);
        rd(IDX_WD_OPTION, 34'h0);
        wr(IDX_WD_OPTION, 8'h01);
        wr(IDX_WD_OPTION, 8'h03);
        rd(IDX_WD_OPTION, 34'h1);
        rd(14'h0001, {RESP_SLVERR, 32'h0});
        wr(14'h0001, 8'hff, RESP_SLVERR);
        t = timer_count;
        @(posedge aclk);
        `CHK(timer_count, t + 16'h1)
        wr(IDX_TEST_CTRL, 8'h01);
        rd(IDX_TEST_CTRL, 34'h0);
        special_mode <= 1'b1;
        wr(IDX_TEST_CTRL, 8'h01);
        rd(IDX_TEST_CTRL, 34'h1);
        t = timer_count;
        @(posedge aclk);
        `CHK(timer_count, {t[15:8] + 8'h1, t[7:0] + 8'h1})
        wr(IDX_TEST_CTRL, 8'h00);
        special_mode <= 1'b0;
        wr(IDX_IRQ_MASK, 8'h40);
        wr(IDX_FLAGS, 8'h40);
        // Every rate, with clears at random points inside the period.
        for (int r = 0; r < 4; r++)
        begin
            per = 0;
            wr(IDX_TICK_CTRL, 8'(r));
            @(posedge aclk);
            per = 16 << r;
            repeat (2)
            begin
                wirq;
                repeat ($random(seed) & 7) @(posedge aclk);
                wr(IDX_FLAGS, 8'h40);
            end
        end
        per = 0;
        wirq;
        wr(IDX_IRQ_MASK, 8'h00);
        rd(IDX_FLAGS, 34'h40);
        `CHK(irq, 1'b0)
        wr(IDX_FLAGS, 8'hbf);
        rd(IDX_FLAGS, 34'h40);
        wstrb <= 4'he;
        wr(IDX_FLAGS, 8'h40);
        rd(IDX_FLAGS, 34'h40);
        wstrb <= 4'h1;
        wr(IDX_IRQ_MASK, 8'h40);
        @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(IDX_FLAGS, 8'h40);
        rd(IDX_FLAGS, 34'h0);
        `CHK(irq, 1'b0)
        final_report;
    end
endmodule
`default_nettype wire
